/* File: hdl/cll_pkg.sv */
package cll_pkg;

	// Register word indices as printed; byte address is four times the index
	localparam logic [7:0]  CLL_IDX_LSB        = 8'h22;
	localparam logic [7:0]  CLL_IDX_MSB        = 8'h23;
	localparam logic [7:0]  CLL_IDX_MODE       = 8'h30;
	localparam logic [7:0]  CLL_IDX_STATUS     = 8'h31;
	localparam logic [7:0]  CLL_IDX_TRIM       = 8'h32;
	localparam logic [11:0] CLL_ADDR_LSB       = {2'b00, CLL_IDX_LSB, 2'b00};
	localparam logic [11:0] CLL_ADDR_MSB       = {2'b00, CLL_IDX_MSB, 2'b00};
	localparam logic [11:0] CLL_ADDR_MODE      = {2'b00, CLL_IDX_MODE, 2'b00};
	localparam logic [11:0] CLL_ADDR_STATUS    = {2'b00, CLL_IDX_STATUS, 2'b00};
	localparam logic [11:0] CLL_ADDR_TRIM      = {2'b00, CLL_IDX_TRIM, 2'b00};

	// Field layout and reset values
	localparam int          CLL_LSB_W          = 8;
	localparam int          CLL_MSB_W          = 4;
	localparam int          CLL_LEN_W          = 12;
	localparam int          CLL_MODE_W         = 2;
	localparam logic [7:0]  CLL_LSB_RST        = 8'h00;
	localparam logic [3:0]  CLL_MSB_RST        = 4'h0;
	localparam logic [1:0]  CLL_MODE_RST       = 2'h0;
	localparam logic [7:0]  CLL_TRIM_RST       = 8'h00;

	// Input arrangement codes
	localparam logic [1:0]  CLL_MODE_SINGLE    = 2'h0;
	localparam logic [1:0]  CLL_MODE_ODD_EVEN  = 2'h1;
	localparam logic [1:0]  CLL_MODE_LEFT_RIGHT = 2'h2;
	localparam logic [1:0]  CLL_MODE_TWO_STREAM = 2'h3;

	typedef enum logic [2:0]
	{
		CLL_ST_IDLE = 3'b001,
		CLL_ST_LINE = 3'b010,
		CLL_ST_DONE = 3'b100
	} cll_state_t;

endpackage : cll_pkg

/* File: hdl/cll_apb_slave.sv */
`timescale 1ns/1ps
// Zero-wait APB slave front end: decodes one access per handshake
module cll_apb_slave
	import cll_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_rdata,
	input  wire logic        i_hit,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	output logic             o_wr,
	output logic             o_rd
);

	typedef struct packed
	{
		logic [31:0] rdata;
	} cll_apb_st_t;

	cll_apb_st_t st_r;
	cll_apb_st_t st_nxt;
	logic        access;

	assign access    = i_psel && i_penable;
	assign o_pready  = 1'b1;
	assign o_pslverr = access && !i_hit;
	assign o_wr      = access && i_pwrite && i_hit;
	assign o_rd      = i_psel && !i_penable && !i_pwrite;
	assign o_prdata  = st_r.rdata;

	always_comb
	begin
		st_nxt = st_r;
		if (o_rd)
		begin
			st_nxt.rdata = i_hit ? i_rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

endmodule : cll_apb_slave

/* File: hdl/cll_line_counter.sv */
`timescale 1ns/1ps
// Counts pixels of one active line against a programmed length
module cll_line_counter
	import cll_pkg::*;
#(
	parameter int LEN_W = CLL_LEN_W
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_enable,
	input  wire logic             i_line_start,
	input  wire logic             i_pixel_valid,
	input  wire logic [LEN_W-1:0] i_length,
	output logic                  o_pixel_take,
	output logic                  o_line_end,
	output logic                  o_busy,
	output logic [LEN_W-1:0]      o_count
);

	// Elaboration-time width check
	if (LEN_W < 1 || LEN_W > 16)
	begin : g_bad_len_w
		$error("cll_line_counter: LEN_W out of range");
	end

	typedef struct packed
	{
		cll_state_t       state;
		logic [LEN_W-1:0] count;
		logic             line_end;
	} cll_cnt_st_t;

	cll_cnt_st_t st_r;
	cll_cnt_st_t st_nxt;

	assign o_busy       = (st_r.state == CLL_ST_LINE);
	assign o_pixel_take = o_busy && i_pixel_valid;
	assign o_line_end   = st_r.line_end;
	assign o_count      = st_r.count;

	always_comb
	begin
		st_nxt          = st_r;
		st_nxt.line_end = 1'b0;
		case (st_r.state)
			CLL_ST_IDLE:
			begin
				if (i_enable && i_line_start && i_length != '0)
				begin
					st_nxt.state = CLL_ST_LINE;
					st_nxt.count = '0;
				end
			end
			CLL_ST_LINE:
			begin
				if (!i_enable)
				begin
					st_nxt.state = CLL_ST_IDLE;
				end
				else if (i_pixel_valid)
				begin
					st_nxt.count = st_r.count + LEN_W'(1);
					if (st_r.count + LEN_W'(1) == i_length)
					begin
						st_nxt.state    = CLL_ST_DONE;
						st_nxt.line_end = 1'b1;
					end
				end
			end
			CLL_ST_DONE:
			begin
				st_nxt.state = CLL_ST_IDLE;
			end
			default:
			begin
				st_nxt.state = CLL_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r.state    <= CLL_ST_IDLE;
			st_r.count    <= '0;
			st_r.line_end <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

endmodule : cll_line_counter

/* File: hdl/cll_chb_line_length.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Single-input arrangement ignores the channel B length; no effect on video.
// - Odd/even arrangement: length counts even pixels per line on channel B.
// - Left/right arrangement: length counts right-side pixels, channel B in and out.
// - Two-stream arrangement: length counts pixels of channel B's own stream.
// - Low register bits 7-0 hold length bits 7-0, read/write, reset zero.
// - High register bits 3-0 hold length bits 11-8, reset zero, 7-4 reserved.
module cll_chb_line_length
	import cll_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	input  wire logic        i_line_start,
	input  wire logic        i_pixel_valid,
	output logic             o_pixel_take,
	output logic             o_pixel_even,
	output logic             o_line_end,
	output logic             o_active,
	output logic [11:0]      o_line_length
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed
	{
		logic [CLL_LSB_W-1:0]  len_lsb;
		logic [CLL_MSB_W-1:0]  len_msb;
		logic [CLL_MODE_W-1:0] mode;
		logic [7:0]            trim;
		logic [CLL_LEN_W-1:0]  length;
		logic                  enable;
		logic [15:0]           lines_done;
	} cll_top_st_t;

	cll_top_st_t st_r;
	cll_top_st_t st_nxt;

	logic                 wr;
	logic                 rd;
	logic                 hit;
	logic [31:0]          rdata;
	logic                 busy;
	logic                 line_end;
	logic [CLL_LEN_W-1:0] count;

	////////////////////////////////////////////////////////////////////////////
	// Bus front end

	assign hit = (i_paddr == CLL_ADDR_LSB) || (i_paddr == CLL_ADDR_MSB)
		|| (i_paddr == CLL_ADDR_MODE) || (i_paddr == CLL_ADDR_STATUS)
		|| (i_paddr == CLL_ADDR_TRIM);

	cll_apb_slave cll_apb_slave_inst
	(
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_rdata   (rdata),
		.i_hit     (hit),
		.o_pready  (o_pready),
		.o_pslverr (o_pslverr),
		.o_prdata  (o_prdata),
		.o_wr      (wr),
		.o_rd      (rd)
	);

	// Read mux; reserved bits read as zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		case (i_paddr)
			CLL_ADDR_LSB:    rdata = {24'h00_0000, st_r.len_lsb};
			CLL_ADDR_MSB:    rdata = {28'h000_0000, st_r.len_msb};
			CLL_ADDR_MODE:   rdata = {30'h0000_0000, st_r.mode};
			CLL_ADDR_TRIM:   rdata = {24'h00_0000, st_r.trim};
			CLL_ADDR_STATUS: rdata = {3'h0, busy, count, st_r.lines_done};
			default:         rdata = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Register and length logic

	function automatic logic [CLL_LEN_W-1:0] join_len(input logic [3:0] msb,
		input logic [7:0] lsb);
		join_len = {msb, lsb};
	endfunction : join_len

	always_comb
	begin
		st_nxt = st_r;
		if (wr && i_pstrb[0])
		begin
			case (i_paddr)
				CLL_ADDR_LSB:  st_nxt.len_lsb = i_pwdata[7:0];
				CLL_ADDR_MSB:  st_nxt.len_msb = i_pwdata[3:0];
				CLL_ADDR_MODE: st_nxt.mode    = i_pwdata[1:0];
				CLL_ADDR_TRIM: st_nxt.trim    = i_pwdata[7:0];
				default:       st_nxt.trim    = st_r.trim;
			endcase
		end
		// Channel B length only drives the path in dual-input arrangements
		case (st_nxt.mode)
			CLL_MODE_SINGLE:     st_nxt.enable = 1'b0;
			CLL_MODE_ODD_EVEN:   st_nxt.enable = 1'b1;
			CLL_MODE_LEFT_RIGHT: st_nxt.enable = 1'b1;
			CLL_MODE_TWO_STREAM: st_nxt.enable = 1'b1;
			default:             st_nxt.enable = 1'b0;
		endcase
		// Software gives the post-trim count; held at zero while ignored
		st_nxt.length = st_nxt.enable ? join_len(st_nxt.len_msb, st_nxt.len_lsb)
			: 12'h000;
		if (line_end)
		begin
			st_nxt.lines_done = st_r.lines_done + 16'h0001;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r.len_lsb    <= CLL_LSB_RST;
			st_r.len_msb    <= CLL_MSB_RST;
			st_r.mode       <= CLL_MODE_RST;
			st_r.trim       <= CLL_TRIM_RST;
			st_r.length     <= {CLL_MSB_RST, CLL_LSB_RST};
			st_r.enable     <= 1'b0;
			st_r.lines_done <= 16'h0000;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line pixel counting for channel B

	cll_line_counter #(.LEN_W(CLL_LEN_W)) cll_line_counter_inst
	(
		.i_clk         (i_clk),
		.i_rst         (i_rst),
		.i_enable      (st_r.enable),
		.i_line_start  (i_line_start),
		.i_pixel_valid (i_pixel_valid),
		.i_length      (st_r.length),
		.o_pixel_take  (o_pixel_take),
		.o_line_end    (line_end),
		.o_busy        (busy),
		.o_count       (count)
	);

	assign o_line_end    = line_end;
	assign o_active      = st_r.enable;
	assign o_line_length = st_r.length;
	assign o_pixel_even  = o_pixel_take && (st_r.mode == CLL_MODE_ODD_EVEN);

endmodule : cll_chb_line_length

/* File: test/cll_chb_line_length_monitor.sv */
`timescale 1ns/1ps
module cll_chb_line_length_monitor
	import cll_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic        i_pixel_valid,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_pixel_take,
	input wire logic        o_pixel_even,
	input wire logic        o_line_end,
	input wire logic        o_active,
	input wire logic [11:0] o_line_length
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic hit;
	assign hit = i_paddr inside {CLL_ADDR_LSB, CLL_ADDR_MSB, CLL_ADDR_MODE, CLL_ADDR_STATUS,
		CLL_ADDR_TRIM};
	sequence s_acc;
		i_psel && i_penable;
	endsequence
	sequence s_end;
		!o_pixel_take && $past(o_pixel_take) ##1 !o_line_end;
	endsequence
	a_len_reset: assert property ($fell(i_rst) |-> o_line_length == 12'h000 && !o_active)
		else $error("length not zero after reset");
	a_single_zero: assert property (!o_active |-> o_line_length == 12'h000)
		else $error("length visible in single mode");
	a_single_idle: assert property (!o_active && !$past(o_active) |-> !o_pixel_take)
		else $error("pixel taken in single mode");
	a_even_mode: assert property (o_pixel_even |-> o_pixel_take && o_active)
		else $error("even flag without take");
	a_take_valid: assert property (o_pixel_take |-> i_pixel_valid)
		else $error("take without valid");
	a_end_pulse: assert property (o_line_end |-> s_end)
		else $error("line end misplaced");
	a_zero_wait: assert property (s_acc |-> o_pready)
		else $error("ready low in access");
	a_err_map: assert property (s_acc |-> o_pslverr == !hit)
		else $error("error flag wrong");
	a_len_hold: assert property (!$past(i_rst) && !$past(i_psel) && !$past(i_psel, 2)
		|-> $stable(o_line_length))
		else $error("length moved without write");
endmodule : cll_chb_line_length_monitor
bind cll_chb_line_length cll_chb_line_length_monitor u_mon (.i_clk, .i_rst, .i_psel,
	.i_penable, .i_paddr, .i_pixel_valid, .o_pready, .o_pslverr, .o_pixel_take,
	.o_pixel_even, .o_line_end, .o_active, .o_line_length);

/* File: test/test_cll_chb_line_length.sv */
`timescale 1ns/1ps
module test_cll_chb_line_length
	import cll_pkg::*;
;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [3:0]  i_pstrb = 4'hF;
	logic        i_line_start = 1'b0;
	logic        i_pixel_valid = 1'b0;
	logic        o_pready, o_pslverr, o_pixel_take, o_pixel_even, o_line_end, o_active;
	logic [31:0] o_prdata, rd;
	logic [11:0] o_line_length;
	logic        err;
	int          mismatches = 0;
	int          compares = 0;
	always #20 i_clk = ~i_clk;
	cll_chb_line_length cll_chb_line_length_inst (.i_clk, .i_rst, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr, .o_prdata,
		.i_line_start, .i_pixel_valid, .o_pixel_take, .o_pixel_even, .o_line_end,
		.o_active, .o_line_length);
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 0,
		input logic [3:0] s = 4'hF);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			mismatches++;
			end_sim();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic line(input int len, input int evn);
		int t, e, f;
		t = 0;
		e = 0;
		f = 0;
		@(posedge i_clk);
		i_line_start <= 1'b1;
		@(posedge i_clk);
		i_line_start <= 1'b0;
		i_pixel_valid <= 1'b1;
		repeat (8)
		begin
			@(negedge i_clk);
			t += (o_pixel_take === 1'b1);
			e += (o_pixel_even === 1'b1);
			f += (o_line_end === 1'b1);
		end
		@(posedge i_clk);
		i_pixel_valid <= 1'b0;
		chk("takes", t, len);
		chk("evens", e, evn);
		chk("ends", f, len > 0);
	endtask : line
	task automatic len_is(input logic [11:0] v);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk("length", o_line_length, v);
	endtask : len_is
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(0, CLL_ADDR_LSB);
		chk("lsb", rd, 0);
		apb(0, CLL_ADDR_MSB);
		chk("msb", rd, 0);
		$display("reset test done");
		apb(1, CLL_ADDR_LSB, 32'hFFFFFFFF);
		apb(1, CLL_ADDR_MSB, 32'hFFFFFFFF);
		apb(0, CLL_ADDR_LSB);
		chk("lsb", rd, 32'h000000FF);
		apb(0, CLL_ADDR_MSB);
		chk("msb", rd, 32'h0000000F);
		line(0, 0);
		len_is(12'h000);
		chk("active", o_active, 0);
		$display("single test done");
		for (int m = 1; m < 4; m++)
		begin
			apb(1, CLL_ADDR_MSB, 0);
			apb(1, CLL_ADDR_LSB, m + 1);
			apb(1, CLL_ADDR_MODE, m);
			len_is(m + 1);
			chk("active", o_active, 1);
			line(m + 1, (m == 1) ? m + 1 : 0);
		end
		apb(0, CLL_ADDR_STATUS);
		chk("status", rd, 32'h0004_0003);
		$display("mode test done");
		apb(1, CLL_ADDR_MSB, 32'h5);
		apb(1, CLL_ADDR_LSB, 32'h3A);
		len_is(12'h53A);
		apb(1, CLL_ADDR_LSB, 32'h11, 4'h0);
		len_is(12'h53A);
		apb(1, 12'hFFC, 32'h77);
		apb(0, 12'hFFC);
		chk("bad rd", rd, 0);
		chk("bad err", err, 1);
		apb(1, CLL_ADDR_MODE, 2);
		apb(1, CLL_ADDR_TRIM, 32'h4);
		apb(1, CLL_ADDR_MSB, 0);
		apb(1, CLL_ADDR_LSB, 32'h2);
		line(2, 0);
		apb(0, CLL_ADDR_TRIM);
		chk("trim", rd, 32'h0000_0004);
		apb(0, CLL_ADDR_MODE);
		chk("mode", rd, 32'h0000_0002);
		$display("trim test done");
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(0, CLL_ADDR_LSB);
		chk("lsb", rd, 0);
		len_is(12'h000);
		$display("second reset test done");
		end_sim();
	end
endmodule : test_cll_chb_line_length
